// ==== src/bsd_pkg.sv ====
// shared constants, types and states of the byte-wide sram bus decoder
`default_nettype none
package bsd_pkg;
  // core-side address space and byte-wide bus widths
  localparam int ADDR_W = 17;
  localparam int BUS_ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int NUM_BLOCKS = 4;
  // address bits that pick one of four 32k blocks, or go out as upper sram address
  localparam int BLOCK_MSB = 16;
  localparam int BLOCK_LSB = 15;
  localparam int UPPER_A16_BIT = 16;
  localparam int UPPER_A15_BIT = 15;
  // chip-enable vector positions
  localparam int SEL_FIRST = 0;
  localparam int SEL_SECOND = 1;
  localparam int SEL_THIRD = 2;
  localparam int SEL_FOURTH = 3;
  // clock rate and sram access time
  localparam int CLK_MHZ = 200;
  localparam int ACCESS_TIME_NS = 70;
  // least time, rounded up to whole cycles
  localparam int ACCESS_CYC = (ACCESS_TIME_NS * CLK_MHZ + 999) / 1000;
  // reset values
  localparam logic [NUM_BLOCKS-1:0] SEL_ALL_OFF = 4'hF;
  localparam logic [BUS_ADDR_W-1:0] BUS_ADDR_RST = 15'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] REQ_ADDR_RST = 17'h00000;

  // one core request toward the byte-wide bus
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic [DATA_W-1:0] wdata;
  } bsd_req_t;

  // access sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SETUP = 4'h2,
    ST_ACTIVE = 4'h4,
    ST_RECOVER = 4'h8
  } bsd_state_t;
endpackage
`default_nettype wire

// ==== src/bsd_select_decode.sv ====
// chip-enable and upper address decode for the byte-wide sram bus
`default_nettype none
module bsd_select_decode (
  input wire logic [bsd_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_enable,
  input wire logic i_sram_size_select,
  input wire logic i_on_backup_cell,
  output logic [bsd_pkg::NUM_BLOCKS-1:0] o_select_n
);

  // one-hot block pick from the two upper address bits
  function automatic logic [bsd_pkg::NUM_BLOCKS-1:0] block_onehot(input logic [1:0] blk);
    logic [bsd_pkg::NUM_BLOCKS-1:0] v;
    v = 4'h0;
    v[blk] = 1'b1;
    return v;
  endfunction

  // four 32k parts: while enabled exactly one select low, chosen by the block bits; none low when not enabled
  wire [bsd_pkg::NUM_BLOCKS-1:0] four_sel = i_enable ?
    block_onehot(i_addr[bsd_pkg::BLOCK_MSB:bsd_pkg::BLOCK_LSB]) : 4'h0;
  wire [bsd_pkg::NUM_BLOCKS-1:0] four_sel_n = ~four_sel;

  // one 128k part: first select is the chip select, second and third carry a16 and a15
  wire [bsd_pkg::NUM_BLOCKS-1:0] big_sel_n = {
    1'b1,                              // fourth unused, held inactive
    i_addr[bsd_pkg::UPPER_A15_BIT],
    i_addr[bsd_pkg::UPPER_A16_BIT],
    ~i_enable
  };

  // size pin picks the scheme; backup forces every select high
  wire [bsd_pkg::NUM_BLOCKS-1:0] mode_sel_n = i_sram_size_select ? four_sel_n : big_sel_n;
  assign o_select_n = i_on_backup_cell ? bsd_pkg::SEL_ALL_OFF : mode_sel_n;

endmodule
`default_nettype wire

// ==== src/bsd_sram_bus.sv ====
// byte-wide sram bus sequencer with block decode and write protection
//
// Functional notes
// - memory selected only by chip enables
// - first select is primary memory select
// - second select for second 32k block
// - third select for third 32k block
// - 128k mode: second/third carry a16/a15
// - no write strobe into program memory
// - all selects high while on backup cell
// - separate 8-bit bidirectional data bus
// - fourth select for fourth block, else idle
// - size pin high four parts, low one
//
// access timing, request taken at edge 0, N = ACCESS_CYC:
//   cycle 1          setup: address, select and write data out, strobe high
//   cycles 2 to N+1  strobe window; a read samples the bus at its last edge
//   cycle N+2        recovery: select, address and data still held
//   cycle N+3        done pulse and ready high, selects released
// a write below the partition gets a refusal pulse in cycle 1 instead;
// it never reaches the pins and ready stays high for it
// losing main supply aborts an access at the next edge and drops done;
// the part keeps what it held, but a byte cut mid-write may be partly written
// in 128k mode the second and third selects are address lines and so follow
// the last request even while idle; the fourth is never used there
// the access time is a parameter; the part must meet it at the clock in use
`default_nettype none
module bsd_sram_bus #(
  parameter int ACCESS_CYC = bsd_pkg::ACCESS_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_req_valid,
  input wire bsd_pkg::bsd_req_t i_req,
  input wire logic [bsd_pkg::ADDR_W-1:0] i_prog_limit,
  input wire logic i_on_backup_cell,
  input wire logic i_sram_size_select,
  input wire logic [bsd_pkg::DATA_W-1:0] i_sram_data_bus,
  output logic o_req_ready,
  output logic [bsd_pkg::BUS_ADDR_W-1:0] o_sram_addr_bus,
  output logic o_block_select_first_n,
  output logic o_block_select_second_n,
  output logic o_block_select_third_n,
  output logic o_block_select_fourth_n,
  output logic o_sram_write_n,
  output logic [bsd_pkg::DATA_W-1:0] o_sram_data_bus,
  output logic o_sram_data_bus_oe_n,
  output logic [bsd_pkg::DATA_W-1:0] o_rd_data,
  output logic o_done,
  output logic o_write_refused
);

  // the window counter runs from ACCESS_CYC-1 down to zero, one step a cycle
  localparam int CNT_W = $clog2(ACCESS_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(ACCESS_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // registered sequencer state, latched request and window count, with next values
  bsd_pkg::bsd_state_t state;
  bsd_pkg::bsd_state_t next_state;
  bsd_pkg::bsd_req_t cur;
  bsd_pkg::bsd_req_t next_cur;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [bsd_pkg::DATA_W-1:0] next_rd_data;
  logic next_done;
  logic next_refused;
  logic [bsd_pkg::NUM_BLOCKS-1:0] next_select_n;

  // partition test: addresses below the limit belong to program memory
  function automatic logic below_partition(input logic [bsd_pkg::ADDR_W-1:0] addr,
    input logic [bsd_pkg::ADDR_W-1:0] limit);
    return addr < limit;
  endfunction

  // request acceptance and write-protect check against the program partition
  wire take = i_req_valid && o_req_ready && !i_on_backup_cell;
  wire in_program = below_partition(i_req.addr, i_prog_limit);
  wire refuse = take && i_req.write && in_program;
  wire start = take && !refuse;
  wire cnt_end = cnt == CNT_ZERO;

  // sequencer: setup one cycle, strobe for the access time, one recovery cycle
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_cnt = cnt;
    next_rd_data = o_rd_data;
    next_done = 1'b0;
    next_refused = refuse;
    case (state)
      bsd_pkg::ST_IDLE: begin
        // a refused write leaves the sequencer idle; only the pulse answers it
        if (start) begin
          next_cur = i_req;
          next_state = bsd_pkg::ST_SETUP;
        end
      end
      bsd_pkg::ST_SETUP: begin
        // address and select settle for a cycle before the strobe opens
        next_cnt = CNT_LOAD;
        next_state = bsd_pkg::ST_ACTIVE;
      end
      bsd_pkg::ST_ACTIVE: begin
        if (cnt_end) begin
          // sample at the close of the access window, while the part still drives
          if (!cur.write) begin
            next_rd_data = i_sram_data_bus;
          end
          next_state = bsd_pkg::ST_RECOVER;
        end else begin
          // strobe stays open while the count runs down
          next_cnt = cnt - 1'b1;
        end
      end
      bsd_pkg::ST_RECOVER: begin
        // select and data hold one more cycle so a write ends cleanly
        next_done = 1'b1;
        next_state = bsd_pkg::ST_IDLE;
      end
      default: begin
        // unreachable with one-hot codes; fall back to idle
        next_state = bsd_pkg::ST_IDLE;
      end
    endcase
    // losing main supply aborts any access; the part keeps its old contents
    if (i_on_backup_cell) begin
      next_state = bsd_pkg::ST_IDLE;
      next_done = 1'b0;
    end
  end

  // pin values for the coming cycle, derived from the next state
  wire next_bus_busy = next_state != bsd_pkg::ST_IDLE;
  wire next_strobe_phase = next_state == bsd_pkg::ST_ACTIVE;
  // second guard: the partition may move while an access is in flight
  wire next_prot = below_partition(next_cur.addr, i_prog_limit);
  wire next_write_n = !(next_strobe_phase && next_cur.write && !next_prot && !i_on_backup_cell);
  // the bus is driven only for writes, from setup through recovery for data hold
  wire next_data_oe_n = !(next_bus_busy && next_cur.write && !i_on_backup_cell);
  wire next_ready = (next_state == bsd_pkg::ST_IDLE) && !i_on_backup_cell;
  // only the low 15 bits go out; block decode stands in for the rest
  wire [bsd_pkg::BUS_ADDR_W-1:0] next_bus_addr = next_cur.addr[bsd_pkg::BUS_ADDR_W-1:0];

  // chip enables: block decode or upper address, forced off on backup
  bsd_select_decode u_decode (
    .i_addr(next_cur.addr),
    .i_enable(next_bus_busy),
    .i_sram_size_select(i_sram_size_select),
    .i_on_backup_cell(i_on_backup_cell),
    .o_select_n(next_select_n)
  );

  // sequencer state
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= bsd_pkg::ST_IDLE;
      cnt <= CNT_ZERO;
      cur <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cur <= next_cur;
    end
  end

  // core-side answers
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_req_ready <= 1'b0;
      o_rd_data <= bsd_pkg::DATA_RST;
      o_done <= 1'b0;
      o_write_refused <= 1'b0;
    end else begin
      o_req_ready <= next_ready;
      o_rd_data <= next_rd_data;
      o_done <= next_done;
      o_write_refused <= next_refused;
    end
  end

  // address and write strobe pins, registered so they switch together
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sram_addr_bus <= bsd_pkg::BUS_ADDR_RST;
      o_sram_write_n <= 1'b1;
    end else begin
      o_sram_addr_bus <= next_bus_addr;
      o_sram_write_n <= next_write_n;
    end
  end

  // data bus drive, separate from the address pins
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sram_data_bus <= bsd_pkg::DATA_RST;
      o_sram_data_bus_oe_n <= 1'b1;
    end else begin
      o_sram_data_bus <= next_cur.wdata;
      o_sram_data_bus_oe_n <= next_data_oe_n;
    end
  end

  // chip-enable pins; a limitation: in 128k mode the second and third follow the address even when idle
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_block_select_first_n <= 1'b1;
      o_block_select_second_n <= 1'b1;
      o_block_select_third_n <= 1'b1;
      o_block_select_fourth_n <= 1'b1;
    end else begin
      o_block_select_first_n <= next_select_n[bsd_pkg::SEL_FIRST];
      o_block_select_second_n <= next_select_n[bsd_pkg::SEL_SECOND];
      o_block_select_third_n <= next_select_n[bsd_pkg::SEL_THIRD];
      o_block_select_fourth_n <= next_select_n[bsd_pkg::SEL_FOURTH];
    end
  end

endmodule
`default_nettype wire

// ==== verification/bsd_sram_bus_monitor.sv ====
// checker bound to the byte-wide sram bus sequencer
`default_nettype none
module bsd_sram_bus_monitor #(
  parameter int ACCESS_CYC = bsd_pkg::ACCESS_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_req_valid,
  input wire bsd_pkg::bsd_req_t i_req,
  input wire logic [bsd_pkg::ADDR_W-1:0] i_prog_limit,
  input wire logic i_on_backup_cell,
  input wire logic i_sram_size_select,
  input wire logic o_req_ready,
  input wire logic [bsd_pkg::BUS_ADDR_W-1:0] o_sram_addr_bus,
  input wire logic o_block_select_first_n,
  input wire logic o_block_select_second_n,
  input wire logic o_block_select_third_n,
  input wire logic o_block_select_fourth_n,
  input wire logic o_sram_write_n,
  input wire logic o_sram_data_bus_oe_n,
  input wire logic o_done,
  input wire logic o_write_refused
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = ACCESS_CYC + 3;
  // selects as one vector, first in bit 0; a take needs idle and main supply
  wire logic [3:0] sel_n = {o_block_select_fourth_n, o_block_select_third_n,
    o_block_select_second_n, o_block_select_first_n};
  wire logic take = i_req_valid && o_req_ready && !i_on_backup_cell;
  wire logic bad = i_req.write && i_req.addr < i_prog_limit;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_go; take && !bad; endsequence
  sequence s_bad; take && bad; endsequence
  property p_off; i_on_backup_cell |=> sel_n == 4'hF && o_sram_write_n && o_sram_data_bus_oe_n; endproperty
  a_off: assert property (p_off) else $error("select on backup");
  property p_refuse; s_bad |=> o_write_refused && o_sram_write_n && o_req_ready; endproperty
  a_refuse: assert property (p_refuse) else $error("write not refused");
  property p_done; s_go |-> ##DLY o_done; endproperty
  a_done: assert property (p_done) else $error("done late");
  property p_block; s_go ##0 i_sram_size_select |=> o_sram_addr_bus == $past(i_req.addr[14:0])
    && sel_n == ~(4'h1 << $past(i_req.addr[16:15])); endproperty
  a_block: assert property (p_block) else $error("block decode");
  property p_upper; s_go ##0 !i_sram_size_select |=> !o_block_select_first_n
    && {o_block_select_second_n, o_block_select_third_n} == $past(i_req.addr[16:15]); endproperty
  a_upper: assert property (p_upper) else $error("upper address");
  property p_fourth; !i_sram_size_select && !$past(i_sram_size_select) |-> o_block_select_fourth_n; endproperty
  a_fourth: assert property (p_fourth) else $error("fourth select used");
  property p_one; i_sram_size_select && $past(i_sram_size_select) |-> $countones(~sel_n) <= 1; endproperty
  a_one: assert property (p_one) else $error("two selects");
  property p_strobe; !o_sram_write_n |-> !o_sram_data_bus_oe_n
    && (i_sram_size_select ? sel_n != 4'hF : !o_block_select_first_n); endproperty
  a_strobe: assert property (p_strobe) else $error("stray strobe");
endmodule
bind bsd_sram_bus bsd_sram_bus_monitor #(.ACCESS_CYC(ACCESS_CYC)) mon_i (.i_core_clk, .i_reset_n,
  .i_req_valid, .i_req, .i_prog_limit, .i_on_backup_cell, .i_sram_size_select, .o_req_ready,
  .o_sram_addr_bus, .o_block_select_first_n, .o_block_select_second_n, .o_block_select_third_n,
  .o_block_select_fourth_n, .o_sram_write_n, .o_sram_data_bus_oe_n, .o_done, .o_write_refused);
`default_nettype wire

// ==== verification/bsd_sram_model.sv ====
// behavioural byte-wide static ram on the far side of the bus
`default_nettype none
module bsd_sram_model (
  input wire logic i_core_clk,
  input wire logic i_write_n,
  input wire logic i_size,
  input wire logic i_oe_n,
  input wire logic [14:0] i_addr,
  input wire logic [3:0] i_sel_n,
  input wire logic [7:0] i_dout,
  output logic [7:0] o_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:131071];
  logic [7:0] last = 8'h00;
  // one part per select, or one big part with two selects as upper address
  wire logic [1:0] blk = i_size ? {!i_sel_n[3] || !i_sel_n[2], !i_sel_n[3] || !i_sel_n[1]}
    : {i_sel_n[1], i_sel_n[2]};
  wire logic hit = i_size ? i_sel_n != 4'hF : !i_sel_n[0];
  // a released bus shows the inverse of its last level, never a stale copy
  assign o_bus = !i_oe_n ? i_dout : (hit && i_write_n) ? mem[{blk, i_addr}] : ~last;
  initial for (int k = 0; k < 131072; k++) mem[k] = 8'h00;
  always @(posedge i_core_clk) begin
    last <= o_bus;
    if (hit && !i_write_n) mem[{blk, i_addr}] <= o_bus;
  end
endmodule
`default_nettype wire

// ==== verification/byte_wide_sram_bus_decoder_test.sv ====
// self-checking bench for the byte-wide sram bus sequencer
`default_nettype none
module byte_wide_sram_bus_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk, i_reset_n, i_req_valid, i_on_backup_cell, i_sram_size_select;
  bsd_pkg::bsd_req_t i_req;
  logic [16:0] i_prog_limit, a;
  logic [7:0] i_sram_data_bus, o_sram_data_bus, o_rd_data;
  logic [14:0] o_sram_addr_bus;
  logic o_req_ready, o_block_select_first_n, o_block_select_second_n, o_block_select_third_n;
  logic o_block_select_fourth_n, o_sram_write_n, o_sram_data_bus_oe_n, o_done, o_write_refused;
  logic [7:0] shadow [0:131071];
  int fail_count, samples_checked;
  wire logic [3:0] sel_n = {o_block_select_fourth_n, o_block_select_third_n,
    o_block_select_second_n, o_block_select_first_n};
  bsd_sram_bus #(.ACCESS_CYC(2)) bsd_sram_bus_i (.i_core_clk, .i_reset_n, .i_req_valid, .i_req,
    .i_prog_limit, .i_on_backup_cell, .i_sram_size_select, .i_sram_data_bus, .o_req_ready,
    .o_sram_addr_bus, .o_block_select_first_n, .o_block_select_second_n, .o_block_select_third_n,
    .o_block_select_fourth_n, .o_sram_write_n, .o_sram_data_bus, .o_sram_data_bus_oe_n, .o_rd_data,
    .o_done, .o_write_refused);
  bsd_sram_model bsd_sram_model_i (.i_core_clk, .i_write_n(o_sram_write_n), .i_size(i_sram_size_select),
    .i_oe_n(o_sram_data_bus_oe_n), .i_addr(o_sram_addr_bus), .i_sel_n(sel_n), .i_dout(o_sram_data_bus),
    .o_bus(i_sram_data_bus));
  initial begin
    i_core_clk = 0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic refused_exp(input logic [16:0] ad, input logic w);
    return w && ad < i_prog_limit;
  endfunction
  // one request held until taken, then wait for done or refusal under a bound
  task automatic xfer(input logic [16:0] ad, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge i_core_clk);
    i_req_valid = 1;
    i_req = '{ad, w, d};
    while (!o_req_ready && n < 50) begin
      @(negedge i_core_clk);
      n++;
    end
    @(negedge i_core_clk);
    i_req_valid = 0;
    while (!(o_done || o_write_refused) && n < 100) begin
      @(negedge i_core_clk);
      n++;
    end
    chk("done", {7'h00, !refused_exp(ad, w)}, {7'h00, o_done});
    chk("refused", refused_exp(ad, w), o_write_refused);
    if (!w) chk("read data", shadow[ad], o_rd_data);
    else if (!refused_exp(ad, w)) shadow[ad] = d;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    $display("Error watchdog expected finish seen timeout");
    tally_and_finish;
  end
  initial begin
    i_reset_n = 0;
    i_req_valid = 0;
    i_req = '0;
    i_prog_limit = 17'h00100;
    i_on_backup_cell = 0;
    i_sram_size_select = 1;
    for (int k = 0; k < 131072; k++) shadow[k] = 8'h00;
    void'($urandom(70449));
    repeat (20) @(posedge i_core_clk);
    @(negedge i_core_clk) i_reset_n = 1;
    // first and last byte of every block in both size modes
    for (int m = 1; m >= 0; m--) begin
      i_sram_size_select = m[0];
      for (int k = 0; k < 8; k++) begin
        xfer({k[2:1], {15{k[0]}}}, 1'h1, 8'($urandom));
        xfer({k[2:1], {15{k[0]}}}, 1'h0, 8'h00);
      end
      $display("test block edges mode %0d done", m);
    end
    // partition boundary, then random traffic under random partitions
    xfer(17'h000FF, 1'h1, 8'hA5);
    xfer(17'h00100, 1'h1, 8'h5A);
    xfer(17'h00100, 1'h0, 8'h00);
    for (int k = 0; k < 60; k++) begin
      i_sram_size_select = 1'($urandom);
      i_prog_limit = {1'h0, 16'($urandom)};
      a = 17'($urandom);
      xfer(a, 1'($urandom), 8'($urandom));
      xfer(a, 1'h0, 8'h00);
    end
    $display("test random traffic done");
    // backup with upper address lines low: all selects high, requests ignored
    i_sram_size_select = 0;
    xfer(17'h00000, 1'h0, 8'h00);
    i_on_backup_cell = 1;
    i_req_valid = 1;
    repeat (10) begin
      @(negedge i_core_clk);
      chk("selects", 8'h0F, {4'h0, sel_n});
      chk("done", 8'h00, {7'h00, o_done});
      chk("ready", 8'h00, {7'h00, o_req_ready});
    end
    i_req_valid = 0;
    i_on_backup_cell = 0;
    $display("test backup done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
